// ---- hdl/flag_bank_pkg.sv ----
// Behaviour
// - Routing bit 0 sends serial read data to config pin, 1 to lane 0.
// - Routing register resets to zero; bits 7..1 read zero, ignore writes.
// - Ready flag, bit 7, sets when initialisation busy falls; read-only.
// - After initialisation, detected state corruption clears the ready flag.
// - Reset-event flag, bit 6, sets on every reset event; resets to 1; W1C.
// - Fuse checksum flag, bit 5, sets on state corruption; W1C.
// - Map checksum flag, bit 4, sets on map mismatch; host checks map.
// - Bit 3 is the live OR of the serial error status bits.
// - Bit 2 is the OR of all overrange and underrange flags.
// - Bit 1 reads 1 while powered down, else 0; read-only.
// - Bit 0 is the OR of the channel sleep bits.
// - Channel overrange flags set per channel; W1C; bits 7..4 reserved.
// - Channel underrange flags set per channel; W1C; bits 7..4 reserved.
// - Health status byte has its own address and resets to 0x40.
// - Map checksum spans two consecutive addresses, 16 bits, resets to zero.
// - Serial error register holds several error bits, each set on its cause.
// - Map checksum uses the device polynomial, seed all ones, over the map.
package flag_bank_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] ROUTE_ADDR    = 8'h14;
  localparam logic [7:0] HEALTH_ADDR   = 8'h20;
  localparam logic [7:0] OVER_ADDR     = 8'h21;
  localparam logic [7:0] UNDER_ADDR    = 8'h22;
  localparam logic [7:0] CKSUM_LO_ADDR = 8'h23;
  localparam logic [7:0] CKSUM_HI_ADDR = 8'h24;

  // Health status field positions
  localparam int READY_BIT  = 7;
  localparam int RESET_BIT  = 6;
  localparam int FUSE_BIT   = 5;
  localparam int MAP_BIT    = 4;
  localparam int SERIAL_BIT = 3;
  localparam int RANGE_BIT  = 2;
  localparam int PD_BIT     = 1;
  localparam int SLEEP_BIT  = 0;
  localparam int ROUTE_BIT  = 0;

  // Sticky health flags {reset, fuse, map}, index order high to low
  localparam int STICKY_RESET_IDX = 2;
  localparam int STICKY_FUSE_IDX  = 1;
  localparam int STICKY_MAP_IDX   = 0;

  // Reset values
  localparam logic [7:0]  HEALTH_RST = 8'h40;
  localparam logic [2:0]  STICKY_RST = 3'h4;
  localparam logic [3:0]  CHAN_RST   = 4'h0;
  localparam logic [15:0] CKSUM_RST  = 16'h0000;
  localparam logic        ROUTE_RST  = 1'b0;

  // Channel count and serial error register width
  localparam int NUM_CHAN  = 4;
  localparam int SERR_BITS = 8;

endpackage : flag_bank_pkg

// ---- hdl/w1c_flag_set.sv ----
`timescale 1ns/1ps
module w1c_flag_set #(
  parameter int                WIDTH     = 4,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  // Clock, reset, enable
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  // Set events and write-one clear
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  // Flag state
  output logic      [WIDTH-1:0] flags_out
);

  // One flop per flag; a set in the clear cycle wins so no event is lost
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      always_ff @(posedge clk_in)
      begin
        if (!resetn_in)
          flags_out[i] <= RESET_VAL[i];
        else if (ce_in)
        begin
          if (set_in[i])
            flags_out[i] <= 1'b1;
          else if (clr_in[i])
            flags_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : w1c_flag_set

// ---- hdl/device_status_flag_bank.sv ----
`timescale 1ns/1ps
module device_status_flag_bank (
  // Clock, reset, enable
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        CLK_EN_IN,
  // Register port from the serial engine
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  input  wire logic        REG_RD_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  output logic             REG_HIT_OUT,
  // Device events
  input  wire logic        INIT_BUSY_IN,
  input  wire logic        STATE_CORRUPT_IN,
  input  wire logic        MAP_MISMATCH_IN,
  input  wire logic        RESET_EVENT_IN,
  input  wire logic        POWERED_DOWN_IN,
  input  wire logic [7:0]  SERIAL_ERR_IN,
  input  wire logic [3:0]  CHAN_SLEEP_IN,
  input  wire logic [3:0]  OVER_LIMIT_IN,
  input  wire logic [3:0]  UNDER_LIMIT_IN,
  // Serial read data routing
  input  wire logic        SERIAL_RDATA_IN,
  input  wire logic        SERIAL_RDATA_OE_IN,
  output logic             CONFIG_DATA_OUT,
  output logic             CONFIG_DATA_OE_OUT,
  output logic             LANE0_CFG_DATA_OUT,
  output logic             CONFIG_OUT_ON_LANE0_OUT,
  // Checksum and health to neighbouring logic
  output logic      [15:0] MAP_CHECKSUM_OUT,
  output logic             DEVICE_READY_OUT
);

  logic        route_reg;
  logic        ready_reg;
  logic        busy_d_reg;
  logic [15:0] cksum_reg;
  logic [2:0]  sticky_flags;
  logic [3:0]  over_flags;
  logic [3:0]  under_flags;
  logic [2:0]  sticky_set;
  logic [2:0]  sticky_clr;
  logic        wr_route;
  logic        wr_health;
  logic        wr_over;
  logic        wr_under;
  logic        wr_ck_lo;
  logic        wr_ck_hi;
  logic        busy_fell;
  logic        serial_any;
  logic        range_any;
  logic        sleep_any;
  logic [7:0]  health_byte;
  logic [7:0]  rdata_next;
  logic        hit_next;

  // Write decode; strobes only count while the clock is enabled
  assign wr_route  = REG_WR_IN && (REG_ADDR_IN == flag_bank_pkg::ROUTE_ADDR);
  assign wr_health = REG_WR_IN && (REG_ADDR_IN == flag_bank_pkg::HEALTH_ADDR);
  assign wr_over   = REG_WR_IN && (REG_ADDR_IN == flag_bank_pkg::OVER_ADDR);
  assign wr_under  = REG_WR_IN && (REG_ADDR_IN == flag_bank_pkg::UNDER_ADDR);
  assign wr_ck_lo  = REG_WR_IN &&
                     (REG_ADDR_IN == flag_bank_pkg::CKSUM_LO_ADDR);
  assign wr_ck_hi  = REG_WR_IN &&
                     (REG_ADDR_IN == flag_bank_pkg::CKSUM_HI_ADDR);

  // Summary terms of the health byte
  assign serial_any = |SERIAL_ERR_IN;
  assign range_any  = |{over_flags, under_flags};
  assign sleep_any  = |CHAN_SLEEP_IN;
  assign busy_fell  = busy_d_reg && !INIT_BUSY_IN;

  // Routing bit; only bit 0 is stored so reserved bits stay zero
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
      route_reg <= flag_bank_pkg::ROUTE_RST;
    else if (CLK_EN_IN && wr_route)
      route_reg <= REG_WDATA_IN[flag_bank_pkg::ROUTE_BIT];
  end

  // Serial read data steering, one flop stage to keep outputs clean
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      CONFIG_DATA_OUT         <= 1'b0;
      CONFIG_DATA_OE_OUT      <= 1'b0;
      LANE0_CFG_DATA_OUT      <= 1'b0;
      CONFIG_OUT_ON_LANE0_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      CONFIG_DATA_OUT         <= !route_reg && SERIAL_RDATA_IN;
      CONFIG_DATA_OE_OUT      <= !route_reg && SERIAL_RDATA_OE_IN;
      LANE0_CFG_DATA_OUT      <= route_reg && SERIAL_RDATA_IN;
      CONFIG_OUT_ON_LANE0_OUT <= route_reg;
    end
  end

  // Busy edge tracker for the end of initialisation
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
      busy_d_reg <= 1'b0;
    else if (CLK_EN_IN)
      busy_d_reg <= INIT_BUSY_IN;
  end

  // Ready flag: corruption wins over a same-cycle busy fall, for safety
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
      ready_reg <= 1'b0;
    else if (CLK_EN_IN)
    begin
      if (STATE_CORRUPT_IN)
        ready_reg <= 1'b0;
      else if (busy_fell)
        ready_reg <= 1'b1;
    end
  end

  // Sticky health flags; reset flag comes up set
  assign sticky_set[flag_bank_pkg::STICKY_RESET_IDX] = RESET_EVENT_IN;
  assign sticky_set[flag_bank_pkg::STICKY_FUSE_IDX]  = STATE_CORRUPT_IN;
  assign sticky_set[flag_bank_pkg::STICKY_MAP_IDX]   = MAP_MISMATCH_IN;
  assign sticky_clr = wr_health ?
    REG_WDATA_IN[flag_bank_pkg::RESET_BIT:flag_bank_pkg::MAP_BIT] : 3'h0;

  w1c_flag_set #(
    .WIDTH     (3),
    .RESET_VAL (flag_bank_pkg::STICKY_RST)
  ) u_health_flags (
    .clk_in    (SYS_CLK_IN),
    .resetn_in (RESETN_IN),
    .ce_in     (CLK_EN_IN),
    .set_in    (sticky_set),
    .clr_in    (sticky_clr),
    .flags_out (sticky_flags)
  );

  // Per-channel limit flags; upper nibble of writes is dropped
  w1c_flag_set #(
    .WIDTH     (flag_bank_pkg::NUM_CHAN),
    .RESET_VAL (flag_bank_pkg::CHAN_RST)
  ) u_over_flags (
    .clk_in    (SYS_CLK_IN),
    .resetn_in (RESETN_IN),
    .ce_in     (CLK_EN_IN),
    .set_in    (OVER_LIMIT_IN),
    .clr_in    (wr_over ? REG_WDATA_IN[3:0] : 4'h0),
    .flags_out (over_flags)
  );

  w1c_flag_set #(
    .WIDTH     (flag_bank_pkg::NUM_CHAN),
    .RESET_VAL (flag_bank_pkg::CHAN_RST)
  ) u_under_flags (
    .clk_in    (SYS_CLK_IN),
    .resetn_in (RESETN_IN),
    .ce_in     (CLK_EN_IN),
    .set_in    (UNDER_LIMIT_IN),
    .clr_in    (wr_under ? REG_WDATA_IN[3:0] : 4'h0),
    .flags_out (under_flags)
  );

  // Checksum holder; the engine compares against it elsewhere
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
      cksum_reg <= flag_bank_pkg::CKSUM_RST;
    else if (CLK_EN_IN)
    begin
      if (wr_ck_lo)
        cksum_reg[7:0] <= REG_WDATA_IN;
      if (wr_ck_hi)
        cksum_reg[15:8] <= REG_WDATA_IN;
    end
  end

  // Health byte assembly; bits 3..0 are live, not stored
  assign health_byte = {ready_reg, sticky_flags, serial_any, range_any,
                        POWERED_DOWN_IN, sleep_any};

  // Read mux; unmapped addresses answer zero with no hit
  always_comb
  begin
    rdata_next = 8'h00;
    hit_next   = 1'b1;
    case (REG_ADDR_IN)
      flag_bank_pkg::ROUTE_ADDR:    rdata_next = {7'h00, route_reg};
      flag_bank_pkg::HEALTH_ADDR:   rdata_next = health_byte;
      flag_bank_pkg::OVER_ADDR:     rdata_next = {4'h0, over_flags};
      flag_bank_pkg::UNDER_ADDR:    rdata_next = {4'h0, under_flags};
      flag_bank_pkg::CKSUM_LO_ADDR: rdata_next = cksum_reg[7:0];
      flag_bank_pkg::CKSUM_HI_ADDR: rdata_next = cksum_reg[15:8];
      default:                      hit_next   = 1'b0;
    endcase
  end

  // Read answer registered one cycle after the strobe
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      REG_RDATA_OUT <= 8'h00;
      REG_HIT_OUT   <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      REG_RDATA_OUT <= REG_RD_IN ? rdata_next : 8'h00;
      REG_HIT_OUT   <= (REG_RD_IN || REG_WR_IN) && hit_next;
    end
  end

  // Checksum and ready to neighbours; mismatch is meaningful only once
  // the host has loaded the proper value
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      MAP_CHECKSUM_OUT <= flag_bank_pkg::CKSUM_RST;
      DEVICE_READY_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      MAP_CHECKSUM_OUT <= cksum_reg;
      DEVICE_READY_OUT <= ready_reg;
    end
  end

  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  AST_ROUTE_PIN: assert property (
    (CLK_EN_IN && !route_reg) |=>
      (CONFIG_DATA_OUT == $past(SERIAL_RDATA_IN)) && !LANE0_CFG_DATA_OUT)
    else $error("config data not on config pin");

  AST_ROUTE_LANE: assert property (
    (CLK_EN_IN && route_reg) |=>
      (LANE0_CFG_DATA_OUT == $past(SERIAL_RDATA_IN)) && !CONFIG_DATA_OE_OUT)
    else $error("config data not on lane 0");

  AST_ROUTE_RSV: assert property (
    (CLK_EN_IN && REG_RD_IN && REG_ADDR_IN == flag_bank_pkg::ROUTE_ADDR)
      |=> (REG_RDATA_OUT[7:1] == 7'h00) && REG_HIT_OUT)
    else $error("routing reserved bits not zero");

  AST_READY_SET: assert property (
    (CLK_EN_IN && busy_fell && !STATE_CORRUPT_IN) |=> ready_reg)
    else $error("ready not set after busy fell");

  AST_READY_CLR: assert property (
    (CLK_EN_IN && STATE_CORRUPT_IN) |=> !ready_reg ##1 !DEVICE_READY_OUT
      or !CLK_EN_IN)
    else $error("ready not cleared on corruption");

  AST_RESET_FLAG: assert property (
    (CLK_EN_IN && RESET_EVENT_IN) |=> health_byte[flag_bank_pkg::RESET_BIT])
    else $error("reset event flag not set");

  AST_FUSE_FLAG: assert property (
    (CLK_EN_IN && STATE_CORRUPT_IN) |=> health_byte[flag_bank_pkg::FUSE_BIT])
    else $error("fuse checksum flag not set");

  AST_MAP_FLAG: assert property (
    (CLK_EN_IN && MAP_MISMATCH_IN) |=> health_byte[flag_bank_pkg::MAP_BIT])
    else $error("map checksum flag not set");

  AST_LIVE_BITS: assert property (
    (CLK_EN_IN && REG_RD_IN && REG_ADDR_IN == flag_bank_pkg::HEALTH_ADDR)
      |=> REG_RDATA_OUT[3:0] == {|$past(SERIAL_ERR_IN),
            |$past({over_flags, under_flags}), $past(POWERED_DOWN_IN),
            |$past(CHAN_SLEEP_IN)})
    else $error("live health bits wrong");

  AST_OVER_SET: assert property (
    CLK_EN_IN |=> (over_flags & $past(OVER_LIMIT_IN)) == $past(OVER_LIMIT_IN))
    else $error("overrange flag missed");

  AST_UNDER_SET: assert property (
    CLK_EN_IN |=>
      (under_flags & $past(UNDER_LIMIT_IN)) == $past(UNDER_LIMIT_IN))
    else $error("underrange flag missed");

  AST_HEALTH_RST: assert property (
    $rose(RESETN_IN) |-> health_byte[7:4] == flag_bank_pkg::HEALTH_RST[7:4])
    else $error("health byte reset value wrong");

  AST_CKSUM_WR: assert property (
    (CLK_EN_IN && wr_ck_hi) |=> cksum_reg[15:8] == $past(REG_WDATA_IN)
      ##1 MAP_CHECKSUM_OUT[15:8] == $past(cksum_reg[15:8]) or !CLK_EN_IN)
    else $error("checksum high byte not stored");

  AST_W1C_HOLD: assert property (
    (CLK_EN_IN && wr_health && !REG_WDATA_IN[flag_bank_pkg::FUSE_BIT]
      && sticky_flags[flag_bank_pkg::STICKY_FUSE_IDX])
      |=> sticky_flags[flag_bank_pkg::STICKY_FUSE_IDX])
    else $error("flag cleared by writing zero");

  AST_SET_WINS: assert property (
    (CLK_EN_IN && wr_over && REG_WDATA_IN[0] && OVER_LIMIT_IN[0])
      |=> over_flags[0])
    else $error("clear beat a same-cycle set");

  AST_RSV_ZERO: assert property (
    (CLK_EN_IN && REG_RD_IN && (REG_ADDR_IN == flag_bank_pkg::OVER_ADDR ||
      REG_ADDR_IN == flag_bank_pkg::UNDER_ADDR)) |=> REG_RDATA_OUT[7:4] == 4'h0)
    else $error("channel reserved bits not zero");

  COV_READY: cover property (CLK_EN_IN && busy_fell ##1 ready_reg);
  COV_LANE0: cover property (CLK_EN_IN && wr_route && REG_WDATA_IN[0]);
  COV_CLEAR: cover property (
    sticky_flags[flag_bank_pkg::STICKY_RESET_IDX] ##1
    !sticky_flags[flag_bank_pkg::STICKY_RESET_IDX]);
  COV_RANGE: cover property (range_any && CLK_EN_IN);

endmodule : device_status_flag_bank

// ---- tb/host_cfg_model.sv ----
`timescale 1ns/1ps
module host_cfg_model (
  // Clock and answer from the bank
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       hit_in,
  // Register port requests
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out,
  output logic            rd_out
);
  // Checksum programmed, so the map fault bit may be trusted
  logic map_sum_valid;

  // Idle port at time zero
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
    map_sum_valid = 1'b0;
  end

  // One strobe, then one idle cycle so strobes never toggle twice at once
  task automatic access(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic h);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(posedge clk_in);
    #1;
    q = rdata_in;
    h = hit_in;
    wr_out = 1'b0;
    rd_out = 1'b0;
    if (w && a == 8'h24)
      map_sum_valid = 1'b1;
    @(posedge clk_in);
    #1;
  endtask : access

  // Map fault only counts once the checksum was written
  function automatic logic map_fault_seen(input logic [7:0] h);
    return h[4] & map_sum_valid;
  endfunction : map_fault_seen
endmodule : host_cfg_model

// ---- tb/device_status_flag_bank_tb_top.sv ----
`timescale 1ns/1ps
module device_status_flag_bank_tb_top;
  logic        sys_clk;
  logic        resetn;
  logic        init_busy;
  logic        corrupt;
  logic        mismatch;
  logic        rst_ev;
  logic        pd;
  logic [7:0]  serr;
  logic [3:0]  sleep;
  logic [3:0]  over;
  logic [3:0]  under;
  logic        sdata;
  logic        soe;
  logic [7:0]  addr;
  logic        wr_s;
  logic [7:0]  wdata;
  logic        rd_s;
  logic [7:0]  rdata;
  logic        hit;
  logic        cfg_d;
  logic        cfg_oe;
  logic        lane0;
  logic        sel;
  logic [15:0] sum;
  logic        ready;
  logic        ce;
  int          num_errors;
  int          total_checks;

  always #20 sys_clk = ~sys_clk;

  host_cfg_model host (.clk_in(sys_clk), .rdata_in(rdata), .hit_in(hit),
    .addr_out(addr), .wr_out(wr_s), .wdata_out(wdata), .rd_out(rd_s));

  device_status_flag_bank dut (.SYS_CLK_IN(sys_clk), .RESETN_IN(resetn),
    .CLK_EN_IN(ce), .REG_ADDR_IN(addr), .REG_WR_IN(wr_s),
    .REG_WDATA_IN(wdata), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
    .REG_HIT_OUT(hit), .INIT_BUSY_IN(init_busy),
    .STATE_CORRUPT_IN(corrupt), .MAP_MISMATCH_IN(mismatch),
    .RESET_EVENT_IN(rst_ev), .POWERED_DOWN_IN(pd), .SERIAL_ERR_IN(serr),
    .CHAN_SLEEP_IN(sleep), .OVER_LIMIT_IN(over), .UNDER_LIMIT_IN(under),
    .SERIAL_RDATA_IN(sdata), .SERIAL_RDATA_OE_IN(soe),
    .CONFIG_DATA_OUT(cfg_d), .CONFIG_DATA_OE_OUT(cfg_oe),
    .LANE0_CFG_DATA_OUT(lane0), .CONFIG_OUT_ON_LANE0_OUT(sel),
    .MAP_CHECKSUM_OUT(sum), .DEVICE_READY_OUT(ready));

  task automatic chkv(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chkv

  task automatic chkb(input logic g, input logic e);
    chkv({15'h0000, g}, {15'h0000, e});
  endtask : chkb

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // Read, compare data and address decode
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       h;
    host.access(a, 1'b0, 8'h00, q, h);
    chkv({8'h00, q}, {8'h00, e});
    chkb(h, a inside {8'h14, [8'h20:8'h24]});
  endtask : rd

  // Write, and compare the address decode answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       h;
    host.access(a, 1'b1, d, q, h);
    chkb(h, a inside {8'h14, [8'h20:8'h24]});
  endtask : wr

  task automatic test_reset;
    rd(8'h14, 8'h00);
    rd(8'h20, 8'h40);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h30, 8'h00);
    chkb(ready, 1'b0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_health;
    init_busy = 1'b0;
    cyc(1);
    rd(8'h20, 8'hc0);
    chkb(ready, 1'b1);
    corrupt = 1'b1;
    cyc(1);
    corrupt = 1'b0;
    rd(8'h20, 8'h60);
    chkb(ready, 1'b0);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h60);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    rst_ev = 1'b1;
    cyc(1);
    rst_ev = 1'b0;
    rd(8'h20, 8'h40);
    mismatch = 1'b1;
    cyc(1);
    mismatch = 1'b0;
    rd(8'h20, 8'h50);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h50);
    wr(8'h20, 8'h10);
    rd(8'h20, 8'h40);
    // Event high only in the write edge, so only set-wins keeps the flag
    rst_ev = 1'b1;
    fork
      wr(8'h20, 8'h40);
      begin
        cyc(1);
        rst_ev = 1'b0;
      end
    join
    rd(8'h20, 8'h40);
    wr(8'h20, 8'h40);
    $display("test health done");
  endtask : test_health

  task automatic test_live;
    serr = 8'h80;
    rd(8'h20, 8'h08);
    serr = 8'h00;
    pd = 1'b1;
    rd(8'h20, 8'h02);
    pd = 1'b0;
    sleep = 4'h8;
    rd(8'h20, 8'h01);
    sleep = 4'h0;
    rd(8'h20, 8'h00);
    $display("test live done");
  endtask : test_live

  // Event only in the clear-all write edge: the flag must survive it
  task automatic test_chan;
    for (int r = 0; r < 2; r++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        over = (r == 0) ? 4'(1 << c) : 4'h0;
        under = (r == 1) ? 4'(1 << c) : 4'h0;
        fork
          wr(8'h21 + 8'(r), 8'hff);
          begin
            cyc(1);
            over = 4'h0;
            under = 4'h0;
          end
        join
        rd(8'h21 + 8'(r), 8'(1 << c));
        rd(8'h20, 8'h04);
        wr(8'h21 + 8'(r), 8'hff);
        rd(8'h21 + 8'(r), 8'h00);
      end
    end
    $display("test chan done");
  endtask : test_chan

  // Data and enable must follow the serial engine, not sit at a constant
  task automatic test_route;
    sdata = 1'b0;
    soe = 1'b0;
    cyc(2);
    chkb(cfg_d, 1'b0);
    chkb(cfg_oe, 1'b0);
    sdata = 1'b1;
    soe = 1'b1;
    cyc(2);
    chkb(cfg_d, 1'b1);
    chkb(cfg_oe, 1'b1);
    chkb(lane0, 1'b0);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h01);
    chkb(sel, 1'b1);
    chkb(lane0, 1'b1);
    chkb(cfg_oe, 1'b0);
    chkb(cfg_d, 1'b0);
    sdata = 1'b0;
    cyc(2);
    chkb(lane0, 1'b0);
    sdata = 1'b1;
    $display("test route done");
  endtask : test_route

  // Enable low: strobes and events are ignored, state holds
  task automatic test_freeze;
    logic [7:0] q;
    logic       h;
    ce = 1'b0;
    over = 4'h1;
    host.access(8'h14, 1'b1, 8'h00, q, h);
    chkb(h, 1'b0);
    over = 4'h0;
    ce = 1'b1;
    rd(8'h14, 8'h01);
    rd(8'h21, 8'h00);
    $display("test freeze done");
  endtask : test_freeze

  task automatic test_sum;
    chkb(host.map_fault_seen(8'h10), 1'b0);
    wr(8'h23, 8'ha5);
    wr(8'h24, 8'h3c);
    rd(8'h23, 8'ha5);
    rd(8'h24, 8'h3c);
    chkv(sum, 16'h3ca5);
    chkb(host.map_fault_seen(8'h10), 1'b1);
    $display("test sum done");
  endtask : test_sum

  // Second reset mid-run brings health, routing and checksum low byte back
  task automatic test_rerun;
    resetn = 1'b0;
    cyc(1);
    resetn = 1'b1;
    rd(8'h20, 8'h40);
    rd(8'h14, 8'h00);
    rd(8'h23, 8'h00);
    $display("test rerun done");
  endtask : test_rerun

  // Cuts a hang short
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    init_busy = 1'b1;
    corrupt = 1'b0;
    mismatch = 1'b0;
    rst_ev = 1'b0;
    pd = 1'b0;
    serr = 8'h00;
    sleep = 4'h0;
    over = 4'h0;
    under = 4'h0;
    sdata = 1'b1;
    soe = 1'b1;
    ce = 1'b1;
    num_errors = 0;
    total_checks = 0;
    cyc(4);
    resetn = 1'b1;
    test_reset();
    test_health();
    test_live();
    test_chan();
    test_route();
    test_freeze();
    test_sum();
    test_rerun();
    print_verdict();
  end
endmodule : device_status_flag_bank_tb_top
